// File: include/reset_seq_pkg.sv
// Constants, codes and carrier types of the reset source sequencer
package reset_seq_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned LF_CLOCK_HZ = 31_000;
    localparam int unsigned LF_DIVIDE = CLK_HZ / LF_CLOCK_HZ;
    localparam int unsigned POWER_UP_DELAY_MS = 64;
    localparam int unsigned POWER_UP_DELAY_TICKS = POWER_UP_DELAY_MS * LF_CLOCK_HZ / 1000;
    localparam int unsigned BROWNOUT_FILTER_TIME_NS = 1000;
    localparam int unsigned BROWNOUT_FILTER_CYCLES =
        (BROWNOUT_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PIN_FILTER_TIME_NS = 2000;
    localparam int unsigned PIN_FILTER_CYCLES =
        (PIN_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned APB_ADDR_WIDTH = 12;
    localparam logic [11:0] BROWNOUT_CONTROL_ADDR = 12'h000;
    localparam logic [11:0] PIN_CONTROL_ADDR = 12'h004;
    localparam logic [11:0] RESET_STATUS_ADDR = 12'h008;
    localparam int unsigned SOFT_ENABLE_BIT = 7;
    localparam int unsigned FAST_START_BIT = 6;
    localparam int unsigned READY_BIT = 0;
    localparam logic SOFT_ENABLE_RESET = 1'b1;
    localparam logic FAST_START_RESET = 1'b0;
    localparam int unsigned PULLUP_BIT = 0;
    localparam int unsigned PIN_LEVEL_BIT = 1;
    localparam logic PULLUP_RESET = 1'b0;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned DELAY_RUNNING_BIT = 2;
    localparam int unsigned PIN_FUNCTION_BIT = 3;
    localparam int unsigned BROWNOUT_SEEN_BIT = 4;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // ****************************************
    // Codes and carriers
    // ****************************************
    typedef enum logic [1:0] {
        BROWNOUT_OFF = 2'h0,
        BROWNOUT_SOFT = 2'h1,
        BROWNOUT_AWAKE_ONLY = 2'h2,
        BROWNOUT_ALWAYS = 2'h3
    } brownout_mode_t;

    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_DELAY = 4'h2,
        ST_READY_WAIT = 4'h4,
        ST_RUN = 4'h8
    } seq_state_t;

    typedef struct packed {
        brownout_mode_t brownout_mode_select;
        logic power_up_delay_enable_n;
        logic low_power_supply_monitor_enable_n;
        logic external_reset_pin_enable;
        logic low_voltage_programming_enable;
    } config_word_t;

    typedef struct packed {
        logic power_on_low;
        logic brownout_below;
        logic brownout_analog_ready;
        logic low_power_low;
    } supply_monitor_t;

    typedef struct packed {
        logic watchdog_timer;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic programming_exit;
    } other_reset_t;

endpackage : reset_seq_pkg

// File: core/level_filter.sv
// Level filter that passes a change only after it has held for a set time
`timescale 1ns/100ps
`default_nettype none
module level_filter #(
    parameter int unsigned HOLD_CYCLES = 50,
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw and filtered level
    input wire logic raw,
    output logic filtered
);

    localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES);

    logic [CW-1:0] count;

    // Count how long the raw level has differed; a shorter excursion is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            filtered <= RESET_LEVEL;
        end else if (raw == filtered) begin
            count <= '0;
        end else if (count == LAST) begin
            count <= '0;
            filtered <= raw;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule : level_filter
`default_nettype wire

// File: core/reset_source_sequencer.sv
// Reset source combining, power-up delay, brown-out modes and control registers
`timescale 1ns/100ps
`default_nettype none
module reset_source_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned LF_DIV = LF_DIVIDE,
    parameter int unsigned DELAY_TICKS = POWER_UP_DELAY_TICKS,
    parameter int unsigned BOR_FILTER = BROWNOUT_FILTER_CYCLES,
    parameter int unsigned PIN_FILTER = PIN_FILTER_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration word and device state
    input wire config_word_t config_word,
    input wire logic sleep_active,
    // Supply monitors and other reset requests
    input wire supply_monitor_t supply,
    input wire other_reset_t other_reset,
    // External reset pin
    input wire logic external_reset_pin_n,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic reset_pin_pullup_en,
    output logic pin_input_level,
    // Results
    output logic device_reset_n,
    output logic combined_brownout,
    output logic wake_stall,
    output logic brownout_detector_enable,
    output logic bandgap_force_on
);

    // ****************************************
    // Local sizes
    // ****************************************
    localparam int unsigned DIV_W = $clog2(LF_DIV + 1);
    localparam int unsigned TICK_W = $clog2(DELAY_TICKS + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LF_DIV - 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DELAY_TICKS - 1);

    // ****************************************
    // Decode helpers
    // ****************************************

    // Detector power per mode, sleep state and soft enable
    function automatic logic detector_on(input brownout_mode_t mode,
                                         input logic sleeping,
                                         input logic soft_on);
        logic on;
        on = 1'b0;
        unique case (mode)
            BROWNOUT_ALWAYS: on = 1'b1;
            BROWNOUT_AWAKE_ONLY: on = !sleeping;
            BROWNOUT_SOFT: on = soft_on;
            BROWNOUT_OFF: on = 1'b0;
        endcase
        return on;
    endfunction : detector_on

    // Modes whose start-up waits for a ready detector
    function automatic logic waits_ready(input brownout_mode_t mode);
        return (mode == BROWNOUT_ALWAYS) || (mode == BROWNOUT_AWAKE_ONLY);
    endfunction : waits_ready

    // Modes in which the fast-start bit acts
    function automatic logic fast_start_acts(input brownout_mode_t mode);
        return (mode == BROWNOUT_AWAKE_ONLY) || (mode == BROWNOUT_SOFT);
    endfunction : fast_start_acts

    // ****************************************
    // Declarations
    // ****************************************
    brownout_mode_t mode;
    seq_state_t state;
    seq_state_t next_state;
    logic soft_enable;
    logic fast_start;
    logic sw_pullup;
    logic brownout_seen;
    logic [DIV_W-1:0] div_count;
    logic lf_tick;
    logic [TICK_W-1:0] tick_count;
    logic delay_done;
    logic detector_active;
    logic bor_filtered;
    logic pin_filtered;
    logic pin_function;
    logic pin_reset;
    logic main_brownout;
    logic lp_brownout;
    logic brownout_any;
    logic power_event;
    logic start_ready;
    logic reset_request;
    logic release_meta;
    logic setup_phase;
    logic write_access;
    logic [31:0] read_word;
    logic addr_ok;

    assign mode = config_word.brownout_mode_select;

    // ****************************************
    // Supply and pin conditioning
    // ****************************************

    // Detector is active only when powered and its analog part is ready
    assign detector_active = detector_on(mode, sleep_active, soft_enable)
                             && supply.brownout_analog_ready;

    // Dips shorter than the filter time never raise a brown-out; start_ready still reads the raw level
    level_filter #(
        .HOLD_CYCLES(BOR_FILTER),
        .RESET_LEVEL(1'b0)
    ) u_bor_filter (
        .pclk(pclk),
        .presetn(presetn),
        .raw(supply.brownout_below),
        .filtered(bor_filtered)
    );

    // Glitches on the reset pin are dropped the same way
    level_filter #(
        .HOLD_CYCLES(PIN_FILTER),
        .RESET_LEVEL(1'b1)
    ) u_pin_filter (
        .pclk(pclk),
        .presetn(presetn),
        .raw(external_reset_pin_n),
        .filtered(pin_filtered)
    );

    // Brown-out sources and their union
    assign main_brownout = detector_active && bor_filtered;
    assign lp_brownout = !config_word.low_power_supply_monitor_enable_n
                         && supply.low_power_low;
    assign brownout_any = main_brownout || lp_brownout;

    // Pin reset function is on unless both enables are clear
    assign pin_function = config_word.external_reset_pin_enable
                          || config_word.low_voltage_programming_enable;
    assign pin_reset = pin_function && !pin_filtered;

    // Events that restart the power-up sequence
    assign power_event = supply.power_on_low
                         || brownout_any
                         || other_reset.programming_exit;

    // Start-up waits for a ready detector above threshold where the mode asks
    assign start_ready = !waits_ready(mode)
                         || (detector_active && !supply.brownout_below);

    // ****************************************
    // Low-frequency time base
    // ****************************************

    // Divider giving one enable pulse per low-frequency period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= '0;
            lf_tick <= 1'b0;
        end else if (div_count == DIV_LAST) begin
            div_count <= '0;
            lf_tick <= 1'b1;
        end else begin
            div_count <= div_count + 1'b1;
            lf_tick <= 1'b0;
        end
    end

    // Delay counter runs only in the delay state, regardless of the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= '0;
        end else if (state != ST_DELAY) begin
            tick_count <= '0;
        end else if (lf_tick && !delay_done) begin
            tick_count <= tick_count + 1'b1;
        end
    end

    assign delay_done = lf_tick && (tick_count == TICK_LAST);

    // ****************************************
    // Start-up sequencer
    // ****************************************

    // Next state of the power-up sequence
    always_comb begin
        next_state = state;
        unique case (state)
            ST_HOLD: begin
                if (!power_event) begin
                    if (!config_word.power_up_delay_enable_n) begin
                        next_state = ST_DELAY;
                    end else begin
                        next_state = ST_READY_WAIT;
                    end
                end
            end
            ST_DELAY: begin
                if (power_event) begin
                    next_state = ST_HOLD;
                end else if (delay_done) begin
                    next_state = ST_READY_WAIT;
                end
            end
            ST_READY_WAIT: begin
                if (power_event) begin
                    next_state = ST_HOLD;
                end else if (start_ready) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (power_event) begin
                    next_state = ST_HOLD;
                end
            end
            default: next_state = ST_HOLD;
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Reset output
    // ****************************************

    // Union of every reset source
    assign reset_request = (state != ST_RUN)
                           || pin_reset
                           || other_reset.watchdog_timer
                           || other_reset.reset_instruction
                           || other_reset.stack_overflow
                           || other_reset.stack_underflow;

    // Assert and release alike pass through both stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_meta <= 1'b0;
            device_reset_n <= 1'b0;
        end else begin
            release_meta <= !reset_request;
            device_reset_n <= release_meta;
        end
    end

    // Brown-out side outputs to cause logic and power control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combined_brownout <= 1'b0;
            wake_stall <= 1'b0;
            brownout_detector_enable <= 1'b0;
            bandgap_force_on <= 1'b0;
        end else begin
            combined_brownout <= brownout_any;
            wake_stall <= (mode == BROWNOUT_AWAKE_ONLY) && !sleep_active
                          && !detector_active;
            brownout_detector_enable <= detector_on(mode, sleep_active, soft_enable);
            bandgap_force_on <= fast_start && fast_start_acts(mode);
        end
    end

    // ****************************************
    // Reset pin
    // ****************************************

    // Pin is never driven; pull-up follows the pin function or software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b0;
            reset_pin_pullup_en <= 1'b1;
            pin_input_level <= 1'b0;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b0;
            reset_pin_pullup_en <= pin_function || sw_pullup;
            pin_input_level <= !pin_function && external_reset_pin_n;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite;
    assign addr_ok = (paddr == BROWNOUT_CONTROL_ADDR)
                     || (paddr == PIN_CONTROL_ADDR)
                     || (paddr == RESET_STATUS_ADDR);

    // Read mux; unused bits read zero
    always_comb begin
        read_word = ZERO_WORD;
        if (paddr == BROWNOUT_CONTROL_ADDR) begin
            read_word[SOFT_ENABLE_BIT] = soft_enable;
            read_word[FAST_START_BIT] = fast_start;
            read_word[READY_BIT] = detector_active;
        end else if (paddr == PIN_CONTROL_ADDR) begin
            read_word[PULLUP_BIT] = sw_pullup;
            read_word[PIN_LEVEL_BIT] = pin_filtered;
        end else if (paddr == RESET_STATUS_ADDR) begin
            read_word[MODE_LSB +: 2] = mode;
            read_word[DELAY_RUNNING_BIT] = (state == ST_DELAY);
            read_word[PIN_FUNCTION_BIT] = pin_function;
            read_word[BROWNOUT_SEEN_BIT] = brownout_seen;
        end
    end

    // Read data and error are captured in the setup cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ZERO_WORD;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_phase) begin
                prdata <= pwrite ? ZERO_WORD : read_word;
                pslverr <= !addr_ok;
            end
        end
    end

    // Brown-out control fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_enable <= SOFT_ENABLE_RESET;
            fast_start <= FAST_START_RESET;
        end else if (write_access && paddr == BROWNOUT_CONTROL_ADDR) begin
            soft_enable <= pwdata[SOFT_ENABLE_BIT];
            fast_start <= pwdata[FAST_START_BIT];
        end
    end

    // Software pull-up used while the pin is a plain input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_pullup <= PULLUP_RESET;
        end else if (write_access && paddr == PIN_CONTROL_ADDR) begin
            sw_pullup <= pwdata[PULLUP_BIT];
        end
    end

    // Sticky brown-out record, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_seen <= 1'b0;
        end else if (brownout_any) begin
            brownout_seen <= 1'b1;
        end else if (write_access && paddr == RESET_STATUS_ADDR
                     && pwdata[BROWNOUT_SEEN_BIT]) begin
            brownout_seen <= 1'b0;
        end
    end

endmodule : reset_source_sequencer
`default_nettype wire

// File: testbench/reset_seq_sva.sv
// Concurrent checks on the reset source sequencer ports
`timescale 1ns/100ps
`default_nettype none
module reset_seq_sva
    import reset_seq_pkg::*;
#(
    parameter int unsigned BOR_FILTER = 3,
    parameter int unsigned PIN_FILTER = 3
) (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [APB_ADDR_WIDTH-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Outside inputs
    input wire config_word_t config_word,
    input wire supply_monitor_t supply,
    input wire logic external_reset_pin_n,
    // Results
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_pullup_en,
    input wire logic device_reset_n,
    input wire logic combined_brownout,
    input wire logic brownout_detector_enable,
    input wire logic bandgap_force_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic pin_fn;
    int unsigned low_cnt;
    int unsigned quiet_cnt;
    assign pin_fn = config_word.external_reset_pin_enable
        | config_word.low_voltage_programming_enable;
    // Cycles the enabled pin has been low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt <= 0;
        else low_cnt <= (pin_fn && !external_reset_pin_n) ? low_cnt + 1 : 0;
    end
    // Cycles with the monitor erased and the supply above threshold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) quiet_cnt <= 0;
        else quiet_cnt <= (config_word.low_power_supply_monitor_enable_n
            && !supply.brownout_below) ? quiet_cnt + 1 : 0;
    end
    chk_pin_not_driven: assert property (!reset_pin_oe && !reset_pin_out)
        else $error("reset pin driven");
    chk_por_holds: assert property (supply.power_on_low [*4] |-> !device_reset_n)
        else $error("reset released at power-on");
    chk_pin_holds: assert property (low_cnt > PIN_FILTER + 3 |-> !device_reset_n)
        else $error("pin low released");
    chk_pullup_pin_on: assert property (pin_fn [*2] |-> reset_pin_pullup_en)
        else $error("pull-up off");
    chk_lp_joins_bor: assert property (!config_word.low_power_supply_monitor_enable_n
        && supply.low_power_low |-> ##[1:3] combined_brownout) else $error("low supply lost");
    chk_lp_erased_off: assert property (quiet_cnt > BOR_FILTER + 3 |-> !combined_brownout)
        else $error("brown-out while erased");
    chk_bandgap_mode: assert property (bandgap_force_on |->
        $past(config_word.brownout_mode_select) inside {BROWNOUT_SOFT, BROWNOUT_AWAKE_ONLY})
        else $error("bandgap in wrong mode");
    chk_off_mode_idle: assert property (config_word.brownout_mode_select == BROWNOUT_OFF
        [*2] |-> !brownout_detector_enable) else $error("detector on when off");
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer");
    chk_unmapped_err: assert property (psel && penable && paddr > RESET_STATUS_ADDR
        |-> pslverr) else $error("unmapped accepted");
endmodule : reset_seq_sva
bind reset_source_sequencer reset_seq_sva #(.BOR_FILTER(BOR_FILTER), .PIN_FILTER(PIN_FILTER))
    reset_seq_sva_inst (.*);
`default_nettype wire

// File: testbench/supply_partner.sv
// Behavioural supply monitors and external reset pin driver
`timescale 1ns/100ps
`default_nettype none
module supply_partner
    import reset_seq_pkg::*;
(
    // Clock and scenario controls
    input wire logic pclk,
    input wire logic por,
    input wire logic bo,
    input wire logic lp,
    input wire logic pin_low,
    input wire logic allow,
    // Design side
    input wire logic det_en,
    input wire logic pin_oe,
    input wire logic pin_out,
    output var supply_monitor_t supply,
    output logic pin_n
);
    logic [1:0] warm;
    // Detector reports ready two cycles after it is powered
    always_ff @(posedge pclk) begin
        warm <= (det_en && allow) ? {warm[0], 1'b1} : 2'b00;
    end
    assign supply = '{por, bo, warm[1], lp};
    // Weak pull-up; the outside party pulls the pin low, else the design drives it when its enable is set
    assign pin_n = pin_low ? 1'b0 : (pin_oe ? pin_out : 1'b1);
endmodule : supply_partner
`default_nettype wire

// File: testbench/test_reset_source_sequencer.sv
// Self-checking bench of the reset source sequencer
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_sequencer
    import reset_seq_pkg::*;
;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, pull, pin_lvl, rst_n, cbo, stall, det, bgap, pin_n, low;
    logic sleep = 0, por = 1, bo = 0, lp = 0, pin_low = 0, allow = 0, pin_out, pin_oe;
    config_word_t cfg = '{BROWNOUT_ALWAYS, 1'b0, 1'b1, 1'b1, 1'b0};
    other_reset_t oth = '0;
    supply_monitor_t supply;
    int num_errors = 0, checks_done = 0, cyc = 0;
    row_t rows [7] = '{'{0, 12'h000, 0, 32'h0000_0081, 0}, '{1, 12'h000, 32'h0000_00FF, 0, 0},
        '{0, 12'h000, 0, 32'h0000_00C1, 0}, '{0, 12'h004, 0, 32'h0000_0002, 0},
        '{0, 12'h008, 0, 32'h0000_000B, 0}, '{1, 12'h00C, 32'h0000_00FF, 0, 1},
        '{0, 12'h00C, 0, 32'h0000_0000, 1}};
    reset_source_sequencer #(.LF_DIV(4), .DELAY_TICKS(5), .BOR_FILTER(3), .PIN_FILTER(3))
        reset_source_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .config_word(cfg), .sleep_active(sleep),
        .supply(supply), .other_reset(oth), .external_reset_pin_n(pin_n),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .reset_pin_pullup_en(pull),
        .pin_input_level(pin_lvl), .device_reset_n(rst_n), .combined_brownout(cbo),
        .wake_stall(stall), .brownout_detector_enable(det), .bandgap_force_on(bgap));
    supply_partner supply_partner_inst (.pclk(pclk), .por(por), .bo(bo), .lp(lp),
        .pin_low(pin_low), .allow(allow), .det_en(det), .pin_oe(pin_oe), .pin_out(pin_out),
        .supply(supply), .pin_n(pin_n));
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wait_rst(input int m);
        repeat (m) if (rst_n !== 1'b1) @(posedge pclk);
        chk("device_reset_n", rst_n, 1'b1);
    endtask : wait_rst
    task automatic watch(input int n);
        low = 0;
        repeat (n) begin
            @(posedge pclk);
            if (rst_n !== 1'b1) low = 1;
        end
    endtask : watch
    task complete_run;
        if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        tick(11);
        chk("reset_n in reset", rst_n, 1'b0);
        chk("pullup in reset", pull, 1'b1);
        tick(1);
        presetn <= 1;
        tick(3);
        por <= 0;
        tick(18);
        chk("delay hold", rst_n, 1'b0);
        tick(22);
        chk("ready hold", rst_n, 1'b0);
        allow <= 1;
        wait_rst(20);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", err, rows[i].e);
            if (!rows[i].w) chk("prdata", rd, rows[i].q);
        end
        // Brown-out dip shorter than the filter, then a long one
        bo <= 1;
        tick(2);
        bo <= 0;
        watch(10);
        chk("short dip", low, 1'b0);
        bo <= 1;
        tick(10);
        chk("brownout", cbo, 1'b1);
        chk("brownout reset", rst_n, 1'b0);
        bo <= 0;
        wait_rst(80);
        apb(0, 12'h008, 0);
        chk("cause set", rd, 32'h0000_001B);
        apb(1, 12'h008, 32'h0000_0010);
        apb(0, 12'h008, 0);
        chk("cause cleared", rd, 32'h0000_000B);
        // Low-power monitor enabled, then erased
        cfg.low_power_supply_monitor_enable_n <= 0;
        lp <= 1;
        tick(8);
        chk("lp brownout", cbo, 1'b1);
        chk("lp reset", rst_n, 1'b0);
        lp <= 0;
        wait_rst(80);
        cfg.low_power_supply_monitor_enable_n <= 1;
        lp <= 1;
        watch(8);
        chk("lp erased", low, 1'b0);
        lp <= 0;
        // Pin glitch, then programming exit with the pin held low
        pin_low <= 1;
        tick(2);
        pin_low <= 0;
        watch(10);
        chk("pin glitch", low, 1'b0);
        pin_low <= 1;
        oth.programming_exit <= 1;
        tick(1);
        oth.programming_exit <= 0;
        tick(60);
        chk("pin hold", rst_n, 1'b0);
        pin_low <= 0;
        wait_rst(12);
        // Pin function off, then on through low-voltage programming
        cfg.external_reset_pin_enable <= 0;
        pin_low <= 1;
        watch(8);
        chk("pin ignored", low, 1'b0);
        chk("pin as input", pin_lvl, 1'b0);
        chk("soft pullup", pull, 1'b0);
        pin_low <= 0;
        cfg.low_voltage_programming_enable <= 1;
        tick(3);
        chk("pin level", pin_lvl, 1'b0);
        chk("pullup on", pull, 1'b1);
        // Every mode, fast start and soft enable both set
        for (int m = 0; m < 4; m++) begin
            cfg.brownout_mode_select <= brownout_mode_t'(m);
            tick(4);
            chk("detector", det, m != 0);
            chk("bandgap", bgap, m == 1 || m == 2);
        end
        sleep <= 1;
        tick(4);
        chk("sleep always", det, 1'b1);
        cfg.brownout_mode_select <= BROWNOUT_AWAKE_ONLY;
        tick(4);
        chk("sleep off", det, 1'b0);
        sleep <= 0;
        low = 0;
        repeat (6) begin
            @(posedge pclk);
            low = low | (stall === 1'b1);
        end
        chk("wake stall seen", low, 1'b1);
        chk("wake stall end", stall, 1'b0);
        cfg.brownout_mode_select <= BROWNOUT_SOFT;
        apb(1, 12'h000, 32'h0000_0040);
        tick(4);
        chk("soft off", det, 1'b0);
        chk("fast start", bgap, 1'b1);
        complete_run();
    end
endmodule : test_reset_source_sequencer
`default_nettype wire
